// ### hw/bbm_bus_if.sv
/*
 * Monitored bus-cycle bundle shared by the matcher and its qualifiers.
 * Assumes one cycle attribute set per clock, valid while a bus cycle is seen.
 */
`timescale 1ns/1ps
interface bbm_bus_if;
	logic          valid;
	logic          write;
	logic          fetch;
	logic          dma;
	logic [1:0]    size;
	logic [31:0]   addr;
	logic [31:0]   data;

	modport src (output valid, write, fetch, dma, size, addr, data);
	modport mon (input valid, write, fetch, dma, size, addr, data);
endinterface : bbm_bus_if

// ### hw/bbm_match.sv
/*
 * Masked equality comparator.
 * Assumes a mask bit of one means the bit is not compared.
 */
`timescale 1ns/1ps
module bbm_match #(
	parameter int W = 32
) (
	// operands
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] mask,
	input  wire logic [W-1:0] seen,
	// result
	output wire logic         hit
);
	// every bit equal or masked
	assign hit = &((value ~^ seen) | mask);
endmodule : bbm_match

// ### hw/bbm_pkg.sv
/*
 * Constants, register map and types of the bus break-condition matcher.
 * Assumes a 32-bit internal address and data bus and a byte-addressed register port.
 */
package bbm_pkg;

	// register port and data widths
	localparam int AW     = 8;
	localparam int DW     = 32;
	localparam int CNT_W  = 12;
	localparam int CTRL_W = 11;

	// register offsets (byte addresses)
	localparam logic [AW-1:0] OFF_C1_CTRL  = 8'h00;
	localparam logic [AW-1:0] OFF_C1_ADDR  = 8'h04;
	localparam logic [AW-1:0] OFF_C1_AMASK = 8'h08;
	localparam logic [AW-1:0] OFF_C1_DATA  = 8'h0C;
	localparam logic [AW-1:0] OFF_C1_DMASK = 8'h10;
	localparam logic [AW-1:0] OFF_C1_COUNT = 8'h14;
	localparam logic [AW-1:0] OFF_C1_SAT   = 8'h18;
	localparam logic [AW-1:0] OFF_C2_CTRL  = 8'h1C;
	localparam logic [AW-1:0] OFF_C2_ADDR  = 8'h20;
	localparam logic [AW-1:0] OFF_C2_AMASK = 8'h24;
	localparam logic [AW-1:0] OFF_STATUS   = 8'h28;

	// control register fields
	localparam int C_EN      = 0;
	localparam int C_AEN     = 1;
	localparam int C_DEN     = 2;
	localparam int C_RWEN    = 3;
	localparam int C_RWW     = 4;
	localparam int C_TYPE_LO = 5;
	localparam int C_TYPE_HI = 6;
	localparam int C_SIZE_LO = 7;
	localparam int C_SIZE_HI = 8;
	localparam int C_FETCH   = 9;
	localparam int C_PRE     = 10;

	// status register fields
	localparam int ST_CH1  = 0;
	localparam int ST_CH2  = 1;
	localparam int ST_PRE  = 2;
	localparam int ST_POST = 3;
	localparam int ST_W    = 4;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST  = 11'h000;
	localparam logic [DW-1:0]     WORD_RST  = 32'h0000_0000;
	localparam logic [CNT_W-1:0]  CNT_MIN   = 12'h001;
	localparam logic [CNT_W-1:0]  CNT_ZERO  = 12'h000;
	localparam logic [ST_W-1:0]   ST_RST    = 4'h0;

	// address alignment per access size
	localparam logic [DW-1:0] ALIGN_LONG = 32'hFFFF_FFFC;
	localparam logic [DW-1:0] ALIGN_WORD = 32'hFFFF_FFFE;
	localparam logic [DW-1:0] ALIGN_BYTE = 32'hFFFF_FFFF;

	// compared lane widths
	localparam logic [DW-1:0] LANE_BYTE = 32'h0000_00FF;
	localparam logic [DW-1:0] LANE_WORD = 32'h0000_FFFF;

	typedef enum logic [1:0] {
		TYPE_ANY  = 2'h0,
		TYPE_EXEC = 2'h1,
		TYPE_DMA  = 2'h2
	} bbm_type_t;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} bbm_size_t;

	typedef enum logic [1:0] {
		PC_IDLE = 2'h0,
		PC_PEND = 2'h1,
		PC_RUN  = 2'h2,
		PC_SLOT = 2'h3
	} bbm_pc_state_t;

endpackage : bbm_pkg

// ### hw/bbm_qual.sv
/*
 * Read/write and cycle-type qualifier of one channel.
 * Assumes the monitored bus bundle; fetch cycles count as reads.
 */
`timescale 1ns/1ps
module bbm_qual (
	// monitored cycle
	bbm_bus_if.mon          bus,
	// settings
	input  wire logic       rw_en,
	input  wire logic       rw_write,
	input  wire logic [1:0] ctype,
	// result
	output wire logic       ok
);
	// qualifier terms, disabled ones always pass
	wire rw_ok   = !rw_en || (bus.write == rw_write);
	wire exec_ok = !bus.dma && !bus.fetch;
	wire type_ok = (ctype == bbm_pkg::TYPE_ANY)  ? 1'b1 :
	               (ctype == bbm_pkg::TYPE_EXEC) ? exec_ok :
	               (ctype == bbm_pkg::TYPE_DMA)  ? bus.dma : 1'b0;
	assign ok = bus.valid && rw_ok && type_ok;
endmodule : bbm_qual

// ### hw/bbm_top.sv
/*
 * Bus break-condition matcher: two break channels watching the internal bus.
 * Assumes one bus cycle per clock on the monitor port, in-order issue and
 * retire strobes from the core, and a simple word register port.
 */
`timescale 1ns/1ps

module bbm_top (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// monitored bus cycle
	input  wire logic        mon_valid,
	input  wire logic        mon_write,
	input  wire logic        mon_fetch,
	input  wire logic        mon_dma,
	input  wire logic [1:0]  mon_size,
	input  wire logic [31:0] mon_addr,
	input  wire logic [31:0] mon_data,
	// core execution strobes
	input  wire logic        ex_issue,
	input  wire logic [31:0] ex_pc,
	input  wire logic        ex_slot,
	input  wire logic        ex_retire,
	// break requests
	output wire logic        brk_halt_pre,
	output logic             brk_halt_post,
	output logic             brk_ch1,
	output logic             brk_ch2
);
	localparam int DW = bbm_pkg::DW;
	localparam int CW = bbm_pkg::CTRL_W;
	localparam int NW = bbm_pkg::CNT_W;

	// programmed state
	logic [CW-1:0]          c1_ctrl;
	logic [DW-1:0]          c1_addr;
	logic [DW-1:0]          c1_amask;
	logic [DW-1:0]          c1_data;
	logic [DW-1:0]          c1_dmask;
	logic [NW-1:0]          c1_count;
	logic [NW-1:0]          c1_sat;
	logic [CW-1:0]          c2_ctrl;
	logic [DW-1:0]          c2_addr;
	logic [DW-1:0]          c2_amask;
	logic [bbm_pkg::ST_W-1:0] status;
	logic [DW-1:0]          pend_addr;
	bbm_pkg::bbm_pc_state_t pc_state;
	bbm_pkg::bbm_pc_state_t next_pc_state;

	// monitored cycle into the shared bundle
	bbm_bus_if bus ();
	assign bus.valid = mon_valid;
	assign bus.write = mon_write;
	assign bus.fetch = mon_fetch;
	assign bus.dma   = mon_dma;
	assign bus.size  = mon_size;
	assign bus.addr  = mon_addr;
	assign bus.data  = mon_data;

	// register decode
	wire wr_c1_ctrl  = reg_wr && (reg_addr == bbm_pkg::OFF_C1_CTRL);
	wire wr_c1_addr  = reg_wr && (reg_addr == bbm_pkg::OFF_C1_ADDR);
	wire wr_c1_amask = reg_wr && (reg_addr == bbm_pkg::OFF_C1_AMASK);
	wire wr_c1_data  = reg_wr && (reg_addr == bbm_pkg::OFF_C1_DATA);
	wire wr_c1_dmask = reg_wr && (reg_addr == bbm_pkg::OFF_C1_DMASK);
	wire wr_c1_count = reg_wr && (reg_addr == bbm_pkg::OFF_C1_COUNT);
	wire wr_c1_sat   = reg_wr && (reg_addr == bbm_pkg::OFF_C1_SAT);
	wire wr_c2_ctrl  = reg_wr && (reg_addr == bbm_pkg::OFF_C2_CTRL);
	wire wr_c2_addr  = reg_wr && (reg_addr == bbm_pkg::OFF_C2_ADDR);
	wire wr_c2_amask = reg_wr && (reg_addr == bbm_pkg::OFF_C2_AMASK);
	wire wr_status   = reg_wr && (reg_addr == bbm_pkg::OFF_STATUS);

	// channel one settings
	wire       c1_en   = c1_ctrl[bbm_pkg::C_EN];
	wire       c1_aen  = c1_ctrl[bbm_pkg::C_AEN];
	wire       c1_den  = c1_ctrl[bbm_pkg::C_DEN];
	wire [1:0] c1_size = c1_ctrl[bbm_pkg::C_SIZE_HI:bbm_pkg::C_SIZE_LO];
	wire [1:0] c1_type = c1_ctrl[bbm_pkg::C_TYPE_HI:bbm_pkg::C_TYPE_LO];

	// channel two settings
	wire       c2_en    = c2_ctrl[bbm_pkg::C_EN];
	wire       c2_fetch = c2_ctrl[bbm_pkg::C_FETCH];
	wire       c2_pre   = c2_ctrl[bbm_pkg::C_PRE];
	wire [1:0] c2_type  = c2_ctrl[bbm_pkg::C_TYPE_HI:bbm_pkg::C_TYPE_LO];

	// address alignment forced by the data size
	wire [DW-1:0] c1_align =
		!c1_den                       ? bbm_pkg::ALIGN_BYTE :
		(c1_size == bbm_pkg::SZ_LONG) ? bbm_pkg::ALIGN_LONG :
		(c1_size == bbm_pkg::SZ_WORD) ? bbm_pkg::ALIGN_WORD :
		bbm_pkg::ALIGN_BYTE;
	wire [DW-1:0] c1_addr_eff = c1_addr & c1_align;
	wire [DW-1:0] c1_amsk_eff = c1_amask & c1_align;

	// lane selection, big-endian lane order on the 32-bit bus
	wire [4:0]    byte_sh = {~mon_addr[1:0], 3'h0};
	wire [4:0]    word_sh = {~mon_addr[1], 4'h0};
	wire [DW-1:0] byte_ln = (mon_data >> byte_sh) & bbm_pkg::LANE_BYTE;
	wire [DW-1:0] word_ln = (mon_data >> word_sh) & bbm_pkg::LANE_WORD;
	wire [DW-1:0] data_seen =
		(c1_size == bbm_pkg::SZ_BYTE) ? byte_ln :
		(c1_size == bbm_pkg::SZ_WORD) ? word_ln : mon_data;
	wire [DW-1:0] lane_msk =
		(c1_size == bbm_pkg::SZ_BYTE) ? bbm_pkg::LANE_BYTE :
		(c1_size == bbm_pkg::SZ_WORD) ? bbm_pkg::LANE_WORD : ~bbm_pkg::WORD_RST;
	wire [DW-1:0] c1_data_eff = c1_data & lane_msk;
	wire [DW-1:0] c1_dmsk_eff = c1_dmask | ~lane_msk;

	// comparators
	logic c1_ahit;
	logic c1_dhit;
	logic c2_ahit;
	logic c1_qok;
	logic c2_qok;
	bbm_match #(.W(DW)) u_c1_addr (
		.value (c1_addr_eff),
		.mask  (c1_amsk_eff),
		.seen  (mon_addr),
		.hit   (c1_ahit)
	);
	bbm_match #(.W(DW)) u_c1_data (
		.value (c1_data_eff),
		.mask  (c1_dmsk_eff),
		.seen  (data_seen),
		.hit   (c1_dhit)
	);
	bbm_match #(.W(DW)) u_c2_addr (
		.value (c2_addr),
		.mask  (c2_amask),
		.seen  (mon_addr),
		.hit   (c2_ahit)
	);
	bbm_qual u_c1_qual (
		.bus      (bus),
		.rw_en    (c1_ctrl[bbm_pkg::C_RWEN]),
		.rw_write (c1_ctrl[bbm_pkg::C_RWW]),
		.ctype    (c1_type),
		.ok       (c1_qok)
	);
	bbm_qual u_c2_qual (
		.bus      (bus),
		.rw_en    (c2_ctrl[bbm_pkg::C_RWEN]),
		.rw_write (c2_ctrl[bbm_pkg::C_RWW]),
		.ctype    (c2_type),
		.ok       (c2_qok)
	);

	// channel one combined condition
	wire c1_size_ok = (mon_size == c1_size);
	wire c1_dcond   = c1_dhit && c1_size_ok && c1_ahit && !mon_fetch;
	wire c1_acond   = !c1_aen || c1_ahit;
	wire c1_met     = c1_en && c1_qok && c1_acond &&
	                  (!c1_den || c1_dcond);
	localparam logic [NW-1:0] CNT_ONE = bbm_pkg::CNT_MIN;
	wire [NW-1:0] c1_sat_inc = NW'(c1_sat + CNT_ONE);
	wire c1_fire = c1_met && (c1_sat_inc >= c1_count);

	// channel two address mode and fetch-address mode
	wire c2_amet  = c2_en && !c2_fetch && c2_ahit && c2_qok;
	wire c2_fhit  = c2_en && c2_fetch && mon_valid && mon_fetch &&
	                c2_ahit;
	wire pc_hit   = ex_issue && (ex_pc == pend_addr);

	// count written as zero is taken as the least count
	wire [NW-1:0] count_wr = (reg_wdata[NW-1:0] == bbm_pkg::CNT_ZERO) ?
	                         bbm_pkg::CNT_MIN : reg_wdata[NW-1:0];

	// channel one registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			c1_ctrl  <= bbm_pkg::CTRL_RST;
			c1_addr  <= bbm_pkg::WORD_RST;
			c1_amask <= bbm_pkg::WORD_RST;
			c1_data  <= bbm_pkg::WORD_RST;
			c1_dmask <= bbm_pkg::WORD_RST;
			c1_count <= bbm_pkg::CNT_MIN;
		end else begin
			if (wr_c1_ctrl)  c1_ctrl  <= reg_wdata[CW-1:0];
			if (wr_c1_addr)  c1_addr  <= reg_wdata;
			if (wr_c1_amask) c1_amask <= reg_wdata;
			if (wr_c1_data)  c1_data  <= reg_wdata;
			if (wr_c1_dmask) c1_dmask <= reg_wdata;
			if (wr_c1_count) c1_count <= count_wr;
		end
	end

	// satisfaction counter, restarts at each break; hardware count beats clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			c1_sat <= bbm_pkg::CNT_ZERO;
		end else if (c1_fire) begin
			c1_sat <= bbm_pkg::CNT_ZERO;
		end else if (c1_met) begin
			c1_sat <= c1_sat_inc;
		end else if (wr_c1_sat) begin
			c1_sat <= bbm_pkg::CNT_ZERO;
		end
	end

	// channel two registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			c2_ctrl  <= bbm_pkg::CTRL_RST;
			c2_addr  <= bbm_pkg::WORD_RST;
			c2_amask <= bbm_pkg::WORD_RST;
		end else begin
			if (wr_c2_ctrl)  c2_ctrl  <= reg_wdata[CW-1:0];
			if (wr_c2_addr)  c2_addr  <= reg_wdata;
			if (wr_c2_amask) c2_amask <= reg_wdata;
		end
	end

	// fetch-address tracker: fetch match, issue, retire or slot deferral
	always_comb begin
		next_pc_state = pc_state;
		case (pc_state)
			bbm_pkg::PC_IDLE: begin
				if (c2_fhit)
					next_pc_state = bbm_pkg::PC_PEND;
			end
			bbm_pkg::PC_PEND: begin
				if (!c2_en || !c2_fetch)
					next_pc_state = bbm_pkg::PC_IDLE;
				else if (pc_hit && c2_pre && ex_slot)
					next_pc_state = bbm_pkg::PC_SLOT;
				else if (pc_hit && c2_pre)
					next_pc_state = bbm_pkg::PC_IDLE;
				else if (pc_hit)
					next_pc_state = bbm_pkg::PC_RUN;
			end
			bbm_pkg::PC_RUN: begin
				if (ex_retire || !c2_en)
					next_pc_state = bbm_pkg::PC_IDLE;
			end
			bbm_pkg::PC_SLOT: begin
				if ((ex_issue && !ex_slot) || !c2_en)
					next_pc_state = bbm_pkg::PC_IDLE;
			end
			default: next_pc_state = bbm_pkg::PC_IDLE;
		endcase
	end

	// tracker state and captured fetch address, newest fetch match wins while idle or pending
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_state  <= bbm_pkg::PC_IDLE;
			pend_addr <= bbm_pkg::WORD_RST;
		end else begin
			pc_state <= next_pc_state;
			if (c2_fhit && (pc_state == bbm_pkg::PC_IDLE || pc_state == bbm_pkg::PC_PEND))
				pend_addr <= mon_addr;
		end
	end

	// halt before execution, held off past a delay slot
	wire halt_now  = (pc_state == bbm_pkg::PC_PEND) && c2_en && c2_fetch &&
	                 pc_hit && c2_pre && !ex_slot;
	wire halt_slot = (pc_state == bbm_pkg::PC_SLOT) && c2_en &&
	                 ex_issue && !ex_slot;
	assign brk_halt_pre = halt_now || halt_slot;
	wire post_ev = (pc_state == bbm_pkg::PC_RUN) && c2_en && ex_retire;

	// break pulses, one cycle after the cause
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			brk_ch1       <= 1'b0;
			brk_ch2       <= 1'b0;
			brk_halt_post <= 1'b0;
		end else begin
			brk_ch1       <= c1_fire;
			brk_ch2       <= c2_amet;
			brk_halt_post <= post_ev;
		end
	end

	// sticky break flags, write one to clear, a new event wins
	wire [bbm_pkg::ST_W-1:0] st_set = {post_ev, brk_halt_pre, c2_amet, c1_fire};
	wire [bbm_pkg::ST_W-1:0] st_clr = wr_status ? reg_wdata[bbm_pkg::ST_W-1:0] :
	                                  bbm_pkg::ST_RST;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			status <= bbm_pkg::ST_RST;
		else
			status <= (status & ~st_clr) | st_set;
	end

	// read data selection, unmapped offsets read zero
	wire [DW-1:0] rd_sel =
		(reg_addr == bbm_pkg::OFF_C1_CTRL)  ? DW'(c1_ctrl)  :
		(reg_addr == bbm_pkg::OFF_C1_ADDR)  ? c1_addr       :
		(reg_addr == bbm_pkg::OFF_C1_AMASK) ? c1_amask      :
		(reg_addr == bbm_pkg::OFF_C1_DATA)  ? c1_data       :
		(reg_addr == bbm_pkg::OFF_C1_DMASK) ? c1_dmask      :
		(reg_addr == bbm_pkg::OFF_C1_COUNT) ? DW'(c1_count) :
		(reg_addr == bbm_pkg::OFF_C1_SAT)   ? DW'(c1_sat)   :
		(reg_addr == bbm_pkg::OFF_C2_CTRL)  ? DW'(c2_ctrl)  :
		(reg_addr == bbm_pkg::OFF_C2_ADDR)  ? c2_addr       :
		(reg_addr == bbm_pkg::OFF_C2_AMASK) ? c2_amask      :
		(reg_addr == bbm_pkg::OFF_STATUS)   ? DW'(status)   :
		bbm_pkg::WORD_RST;

	// read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= bbm_pkg::WORD_RST;
		else if (reg_rd)
			reg_rdata <= rd_sel;
		else
			reg_rdata <= bbm_pkg::WORD_RST;
	end

endmodule : bbm_top

// ### tb/bbm_core_model.sv
/* core bus model: turns bench requests into one monitored bus cycle each.
   assumes one request per clock; released address and data lines do not keep their last value. */
`timescale 1ns/1ps
module bbm_core_model (
	// clock
	input  wire logic        sys_clk,
	// request: attr is write, fetch, dma, size
	input  wire logic        req,
	input  wire logic [4:0]  req_attr,
	input  wire logic [31:0] req_addr,
	input  wire logic [31:0] req_data,
	// monitored bus cycle
	output logic             mon_valid,
	output logic             mon_write,
	output logic             mon_fetch,
	output logic             mon_dma,
	output logic [1:0]       mon_size,
	output logic [31:0]      mon_addr,
	output logic [31:0]      mon_data
);
	// idle bus at time zero
	initial begin
		{mon_valid, mon_write, mon_fetch, mon_dma, mon_size} = 6'h00;
		mon_addr = 32'h0;
		mon_data = 32'h0;
	end
	// one cycle per request; idle address and data lines toggle so stale values never match
	always @(posedge sys_clk) begin
		mon_valid <= req;
		if (req) begin
			{mon_write, mon_fetch, mon_dma, mon_size} <= req_attr;
			mon_addr <= req_addr;
			mon_data <= req_data;
		end else begin
			mon_addr <= ~mon_addr;
			mon_data <= ~mon_data;
		end
	end
endmodule : bbm_core_model

// ### tb/bbm_top_properties.sv
/* port checker of the break matcher: qualifiers, break causes, read port idle.
   assumes it is bound into bbm_top and sees its ports only. */
`timescale 1ns/1ps
module bbm_top_chk (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        arst_n,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// monitored cycle and core strobes
	input wire logic        mon_valid,
	input wire logic        mon_write,
	input wire logic        mon_fetch,
	input wire logic        mon_dma,
	input wire logic        ex_issue,
	input wire logic        ex_slot,
	input wire logic        ex_retire,
	// break requests
	input wire logic        brk_halt_pre,
	input wire logic        brk_halt_post,
	input wire logic        brk_ch1,
	input wire logic        brk_ch2
);
	logic [10:0] c1;
	logic [10:0] c2;
	// control write decode and setting taps
	wire c1_wr   = reg_wr && (reg_addr == bbm_pkg::OFF_C1_CTRL);
	wire c2_wr   = reg_wr && (reg_addr == bbm_pkg::OFF_C2_CTRL);
	wire c1_on   = c1[bbm_pkg::C_EN];
	wire c1_den  = c1[bbm_pkg::C_DEN];
	wire c1_rwen = c1[bbm_pkg::C_RWEN];
	wire c1_rww  = c1[bbm_pkg::C_RWW];
	wire c1_dma  = (c1[6:5] == 2'h2);
	wire c2_amod = c2[bbm_pkg::C_EN] && !c2[bbm_pkg::C_FETCH];
	wire c2_pre  = c2[bbm_pkg::C_EN] && c2[bbm_pkg::C_FETCH] && c2[bbm_pkg::C_PRE];
	wire c2_post = c2[bbm_pkg::C_FETCH] && !c2[bbm_pkg::C_PRE];
	// shadow copies of both control registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			c1 <= bbm_pkg::CTRL_RST;
			c2 <= bbm_pkg::CTRL_RST;
		end else begin
			if (c1_wr) begin
				c1 <= reg_wdata[10:0];
			end
			if (c2_wr) begin
				c2 <= reg_wdata[10:0];
			end
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	a_pre_cause: assert property (brk_halt_pre |-> ex_issue && !ex_slot && c2_pre)
		else $error("pre halt without a non-slot issue in pre mode");
	a_post_cause: assert property (brk_halt_post |-> $past(ex_retire) && $past(c2_post))
		else $error("post halt without retire in post mode");
	a_post_single: assert property (brk_halt_post |=> !brk_halt_post)
		else $error("post halt longer than one cycle");
	a_ch2_amode: assert property (brk_ch2 |-> $past(mon_valid) && $past(c2_amod))
		else $error("channel two address break outside address mode");
	a_ch1_cause: assert property (brk_ch1 |-> $past(mon_valid) && $past(c1_on))
		else $error("channel one break without enabled cycle");
	a_data_nofetch: assert property (brk_ch1 && $past(c1_den) |-> !$past(mon_fetch))
		else $error("data break in fetch cycle");
	a_rw_qual: assert property (brk_ch1 && $past(c1_rwen) |-> $past(mon_write) == $past(c1_rww))
		else $error("channel one break on wrong direction");
	a_type_dma: assert property (brk_ch1 && $past(c1_dma) |-> $past(mon_dma))
		else $error("dma-only break on non-dma cycle");
	cover property (brk_ch1);
	cover property (brk_ch2);
	cover property (brk_halt_pre);
	cover property (brk_halt_post);
endmodule : bbm_top_chk

bind bbm_top bbm_top_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.mon_valid(mon_valid), .mon_write(mon_write), .mon_fetch(mon_fetch), .mon_dma(mon_dma),
	.ex_issue(ex_issue), .ex_slot(ex_slot), .ex_retire(ex_retire),
	.brk_halt_pre(brk_halt_pre), .brk_halt_post(brk_halt_post),
	.brk_ch1(brk_ch1), .brk_ch2(brk_ch2));

// ### tb/bbm_top_tb.sv
/* self-checking bench of the break matcher: register port, both channels.
   assumes the core bus model and the bound port checker. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module bbm_top_tb;
	logic        sys_clk   = 1'b0;
	logic        arst_n    = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        req       = 1'b0;
	logic [4:0]  req_attr  = 5'h00;
	logic [31:0] req_addr  = 32'h0;
	logic [31:0] req_data  = 32'h0;
	logic        ex_issue  = 1'b0;
	logic [31:0] ex_pc     = 32'h0;
	logic        ex_slot   = 1'b0;
	logic        ex_retire = 1'b0;
	wire  [31:0] reg_rdata;
	wire         mon_valid, mon_write, mon_fetch, mon_dma;
	wire  [1:0]  mon_size;
	wire  [31:0] mon_addr, mon_data;
	wire         brk_halt_pre, brk_halt_post, brk_ch1, brk_ch2;
	int          n_fail = 0;
	int          checks = 0;
	int          cyc    = 0;
	logic [3:0]  seen   = 4'h0;
	bbm_core_model u_core (.sys_clk(sys_clk), .req(req), .req_attr(req_attr),
		.req_addr(req_addr), .req_data(req_data), .mon_valid(mon_valid),
		.mon_write(mon_write), .mon_fetch(mon_fetch), .mon_dma(mon_dma),
		.mon_size(mon_size), .mon_addr(mon_addr), .mon_data(mon_data));
	bbm_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mon_valid(mon_valid), .mon_write(mon_write), .mon_fetch(mon_fetch),
		.mon_dma(mon_dma), .mon_size(mon_size), .mon_addr(mon_addr), .mon_data(mon_data),
		.ex_issue(ex_issue), .ex_pc(ex_pc), .ex_slot(ex_slot), .ex_retire(ex_retire),
		.brk_halt_pre(brk_halt_pre), .brk_halt_post(brk_halt_post),
		.brk_ch1(brk_ch1), .brk_ch2(brk_ch2));
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	// break pulses seen since the last status clear, sampled mid-cycle
	always @(negedge sys_clk) begin
		if (!arst_n || (reg_wr && reg_addr == bbm_pkg::OFF_STATUS))
			seen <= 4'h0;
		else
			seen <= seen | {brk_halt_post, brk_halt_pre, brk_ch2, brk_ch1};
	end
	// cycle ceiling against hangs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			close_out();
		end
	end
	task close_out();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 `CHK(nm, e, reg_rdata)
	endtask : rd
	task bus(input logic [4:0] at, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= 1'b1;
		req_attr <= at;
		req_addr <= a;
		req_data <= d;
		@(posedge sys_clk);
		req <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask : bus
	// status read, then write-one clear of all events
	task st(input logic [31:0] e);
		rd(bbm_pkg::OFF_STATUS, e, "status");
		`CHK("pulses", e[3:0], seen)
		wr(bbm_pkg::OFF_STATUS, 32'hF);
	endtask : st
	// channel one control, one bus cycle, expected status
	task step(input logic [31:0] c, input logic [4:0] at, input logic [31:0] a,
		input logic [31:0] d, input logic [31:0] e);
		wr(bbm_pkg::OFF_C1_CTRL, c);
		bus(at, a, d);
		st(e);
	endtask : step
	task issue(input logic [31:0] pc, input logic s, input logic e);
		@(posedge sys_clk);
		ex_issue <= 1'b1;
		ex_pc <= pc;
		ex_slot <= s;
		#1 `CHK("halt_pre", e, brk_halt_pre)
		@(posedge sys_clk);
		ex_issue <= 1'b0;
		ex_slot <= 1'b0;
	endtask : issue
	task tend(input string nm);
		$display("test %s done", nm);
	endtask : tend
	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(bbm_pkg::OFF_C1_COUNT, 32'h1, "count");
		rd(bbm_pkg::OFF_C1_SAT, 32'h0, "sat");
		rd(bbm_pkg::OFF_C1_CTRL, 32'h0, "ctrl");
		rd(bbm_pkg::OFF_STATUS, 32'h0, "status");
		wr(8'h3C, 32'hFFFF_FFFF);
		rd(8'h3C, 32'h0, "unmapped");
		wr(bbm_pkg::OFF_C1_COUNT, 32'h0);
		rd(bbm_pkg::OFF_C1_COUNT, 32'h1, "count");
		tend("reset");
		wr(bbm_pkg::OFF_C1_ADDR, 32'h4000);
		wr(bbm_pkg::OFF_C1_AMASK, 32'h000F);
		step(32'h03, 5'h00, 32'h4007, 32'h0, 32'h1);
		step(32'h03, 5'h00, 32'h4017, 32'h0, 32'h0);
		step(32'h1B, 5'h00, 32'h4000, 32'h0, 32'h0);
		step(32'h1B, 5'h10, 32'h4000, 32'h0, 32'h1);
		step(32'h0B, 5'h08, 32'h4000, 32'h0, 32'h1);
		step(32'h23, 5'h04, 32'h4000, 32'h0, 32'h0);
		step(32'h23, 5'h08, 32'h4000, 32'h0, 32'h0);
		step(32'h23, 5'h00, 32'h4000, 32'h0, 32'h1);
		step(32'h43, 5'h04, 32'h4000, 32'h0, 32'h1);
		step(32'h43, 5'h00, 32'h4000, 32'h0, 32'h0);
		step(32'h03, 5'h0A, 32'h4000, 32'h0, 32'h1);
		step(32'h01, 5'h00, 32'h9999, 32'h0, 32'h1);
		tend("address");
		wr(bbm_pkg::OFF_C1_ADDR, 32'h101);
		wr(bbm_pkg::OFF_C1_AMASK, 32'h0);
		wr(bbm_pkg::OFF_C1_DATA, 32'h5A);
		step(32'h07, 5'h00, 32'h101, 32'h005A_0000, 32'h1);
		step(32'h07, 5'h00, 32'h101, 32'h0000_005A, 32'h0);
		step(32'h07, 5'h08, 32'h101, 32'h005A_0000, 32'h0);
		step(32'h07, 5'h01, 32'h101, 32'h005A_0000, 32'h0);
		wr(bbm_pkg::OFF_C1_ADDR, 32'h203);
		wr(bbm_pkg::OFF_C1_DATA, 32'h1234);
		step(32'h87, 5'h01, 32'h202, 32'h0000_1234, 32'h1);
		step(32'h87, 5'h01, 32'h202, 32'h1234_0000, 32'h0);
		wr(bbm_pkg::OFF_C1_ADDR, 32'h303);
		wr(bbm_pkg::OFF_C1_DATA, 32'hDEAD_BEEF);
		step(32'h107, 5'h02, 32'h300, 32'hDEAD_BEEF, 32'h1);
		wr(bbm_pkg::OFF_C1_DMASK, 32'h0000_FFFF);
		step(32'h107, 5'h02, 32'h300, 32'hDEAD_0000, 32'h1);
		step(32'h107, 5'h02, 32'h300, 32'hDEAC_0000, 32'h0);
		tend("data");
		wr(bbm_pkg::OFF_C1_ADDR, 32'h4000);
		wr(bbm_pkg::OFF_C1_COUNT, 32'h3);
		step(32'h03, 5'h00, 32'h4000, 32'h0, 32'h0);
		step(32'h03, 5'h00, 32'h4000, 32'h0, 32'h0);
		rd(bbm_pkg::OFF_C1_SAT, 32'h2, "sat");
		wr(bbm_pkg::OFF_C1_SAT, 32'h0);
		rd(bbm_pkg::OFF_C1_SAT, 32'h0, "sat");
		step(32'h03, 5'h00, 32'h4000, 32'h0, 32'h0);
		step(32'h03, 5'h00, 32'h4000, 32'h0, 32'h0);
		step(32'h03, 5'h00, 32'h4000, 32'h0, 32'h1);
		rd(bbm_pkg::OFF_C1_SAT, 32'h0, "sat");
		wr(bbm_pkg::OFF_C1_CTRL, 32'h0);
		tend("count");
		wr(bbm_pkg::OFF_C2_ADDR, 32'h500);
		wr(bbm_pkg::OFF_C2_CTRL, 32'h1);
		bus(5'h10, 32'h500, 32'h0);
		st(32'h2);
		bus(5'h08, 32'h500, 32'h0);
		st(32'h2);
		bus(5'h10, 32'h504, 32'h0);
		st(32'h0);
		wr(bbm_pkg::OFF_C2_AMASK, 32'hF);
		bus(5'h10, 32'h50C, 32'h0);
		st(32'h2);
		wr(bbm_pkg::OFF_C2_ADDR, 32'h600);
		wr(bbm_pkg::OFF_C2_CTRL, 32'h659);
		bus(5'h10, 32'h600, 32'h0);
		issue(32'h600, 1'b0, 1'b0);
		bus(5'h0A, 32'h600, 32'h0);
		issue(32'h600, 1'b0, 1'b1);
		st(32'h4);
		wr(bbm_pkg::OFF_C2_ADDR, 32'h700);
		bus(5'h0A, 32'h700, 32'h0);
		issue(32'h700, 1'b1, 1'b0);
		issue(32'h704, 1'b0, 1'b1);
		st(32'h4);
		wr(bbm_pkg::OFF_C2_ADDR, 32'h800);
		wr(bbm_pkg::OFF_C2_CTRL, 32'h201);
		bus(5'h0A, 32'h800, 32'h0);
		issue(32'h800, 1'b0, 1'b0);
		@(posedge sys_clk);
		ex_retire <= 1'b1;
		@(posedge sys_clk);
		ex_retire <= 1'b0;
		st(32'h8);
		wr(bbm_pkg::OFF_C2_ADDR, 32'h900);
		wr(bbm_pkg::OFF_C2_CTRL, 32'h601);
		bus(5'h0A, 32'h900, 32'h0);
		wr(bbm_pkg::OFF_C2_CTRL, 32'h0);
		issue(32'h900, 1'b0, 1'b0);
		st(32'h0);
		tend("channel two");
		close_out();
	end
endmodule : bbm_top_tb
